// >>> core/encoder_pwm_io.sv
// Purpose: Register map and core logic of the encoder counter PWM card
// Assumes: I/O base is 256-byte aligned, inputs synchronous to i_clock
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ps
module encoder_pwm_io (
    input  wire logic                         i_clock,
    input  wire logic                         i_sys_rst,
    input  wire logic [15:0]                  i_io_base,
    input  wire encoder_pwm_io_pkg::io_req_s  i_io_req,
    output logic [15:0]                       o_io_rdata,
    output logic                              o_io_rvalid,
    input  wire logic [2:0]                   i_counter_a_input,
    input  wire logic [2:0]                   i_counter_b_input,
    input  wire logic [2:0]                   i_index_pulse_input,
    input  wire logic [2:0]                   i_extra_differential_inputs,
    input  wire logic [7:0]                   i_isolated_input_bits,
    input  wire logic                         i_primary_irq_enable,
    input  wire logic                         i_secondary_irq_enable,
    output logic [7:0]                        o_isolated_output_bits,
    output logic [2:0]                        o_pwm_upper,
    output logic [2:0]                        o_pwm_lower,
    output logic                              o_irq_request
);
    import encoder_pwm_io_pkg::*;

    // ************************************************************
    // State and decode
    // ************************************************************
    card_state_s st_r;
    card_state_s st_nxt;

    logic        hit;
    logic [7:0]  ofs;
    logic        wr_hit;
    logic        rd_hit;
    logic [6:0]  filt_limit;
    logic        tick;
    logic        prim_ev;
    logic        sec_ev;
    logic [15:0] status_word;
    logic [11:0] dead_load;

    // Window decode on the upper address byte
    assign hit    = (i_io_req.addr[15:8] == i_io_base[15:8]);
    assign ofs    = {i_io_req.addr[7:1], 1'b0};
    assign wr_hit = hit & i_io_req.wr;
    assign rd_hit = hit & i_io_req.rd;

    assign status_word = {7'h00, st_r.dir3,
                          1'b1, st_r.idx_flag[0], st_r.idx_flag[1],
                          st_r.idx_flag[2], 1'b1,
                          i_extra_differential_inputs};

    assign dead_load = 12'(({4'h0, st_r.dead_set} + 12'h001)
                       * DEAD_UNIT_CYCLES - 12'h001);

    always_comb begin
        case (st_r.ctrl[CTL_FILT_LO +: 2])
            2'b00:   filt_limit = FILT0_CYCLES;
            2'b01:   filt_limit = FILT1_CYCLES;
            2'b10:   filt_limit = FILT2_CYCLES;
            default: filt_limit = FILT3_CYCLES;
        endcase
    end

    // ************************************************************
    // Counting step helper
    // ************************************************************
    // Returns {increment, decrement} for one sample of the inputs
    function automatic logic [1:0] count_step(
        input count_mode_e mode,
        input logic        a,
        input logic        b,
        input logic        pa,
        input logic        pb
    );
        logic [1:0] res;
        res = 2'b00;
        case (mode)
            MODE_PULSE_DIR: begin
                if (a & ~pa) begin
                    res = b ? 2'b10 : 2'b01;
                end
            end
            MODE_UP_DOWN: begin
                // Both edges together cancel out
                res = {a & ~pa, b & ~pb};
                if (res == 2'b11) begin
                    res = 2'b00;
                end
            end
            default: begin
                // A double change is a lost step and is dropped
                if ((a ^ pa) ^ (b ^ pb)) begin
                    res = (a ^ pb) ? 2'b10 : 2'b01;
                end
            end
        endcase
        return res;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        count_mode_e mode;
        logic        sa;
        logic        sb;
        logic [1:0]  stp;
        logic        raw;
        logic [15:0] dur;
        mode   = MODE_QUAD_FILT;
        sa     = 1'b0;
        sb     = 1'b0;
        stp    = 2'b00;
        raw    = 1'b0;
        dur    = 16'h0000;
        st_nxt = st_r;
        tick    = (st_r.prescale == 5'(TICK_CYCLES - 1));
        prim_ev = 1'b0;
        sec_ev  = 1'b0;

        // Time base and primary timer
        st_nxt.prescale = tick ? 5'h00 : st_r.prescale + 5'h01;
        if (st_r.prim_period == 16'h0000) begin
            // Zero period holds the timer stopped
            st_nxt.tcount = 16'h0000;
        end else if (tick) begin
            if (st_r.tcount >= st_r.prim_period - 16'h0001) begin
                st_nxt.tcount = 16'h0000;
                prim_ev       = 1'b1;
            end else begin
                st_nxt.tcount = st_r.tcount + 16'h0001;
            end
        end

        // Secondary timer and carrier phase
        if (prim_ev) begin
            st_nxt.phase    = ~st_r.phase;
            st_nxt.duty_act = st_r.duty_wr;
            if (st_r.scount >= st_r.sec_mult) begin
                st_nxt.scount = 8'h00;
                sec_ev        = 1'b1;
            end else begin
                st_nxt.scount = st_r.scount + 8'h01;
            end
        end

        // Per-channel filter, decode, count and index capture
        for (int ch = 0; ch < 3; ch++) begin
            if (i_counter_a_input[ch] != st_r.filt_a[ch]) begin
                if (st_r.fcnt_a[ch] + 7'h01 >= filt_limit) begin
                    st_nxt.filt_a[ch] = i_counter_a_input[ch];
                    st_nxt.fcnt_a[ch] = 7'h00;
                end else begin
                    st_nxt.fcnt_a[ch] = st_r.fcnt_a[ch] + 7'h01;
                end
            end else begin
                st_nxt.fcnt_a[ch] = 7'h00;
            end
            if (i_counter_b_input[ch] != st_r.filt_b[ch]) begin
                if (st_r.fcnt_b[ch] + 7'h01 >= filt_limit) begin
                    st_nxt.filt_b[ch] = i_counter_b_input[ch];
                    st_nxt.fcnt_b[ch] = 7'h00;
                end else begin
                    st_nxt.fcnt_b[ch] = st_r.fcnt_b[ch] + 7'h01;
                end
            end else begin
                st_nxt.fcnt_b[ch] = 7'h00;
            end

            case (ch)
                0: begin
                    mode = st_r.ctrl[CTL_C1_MODE] ? MODE_QUAD_FILT
                                                  : MODE_UP_DOWN;
                end
                1: begin
                    mode = count_mode_e'(st_r.ctrl[CTL_C2_MODE_LO +: 2]);
                end
                default: begin
                    mode = MODE_QUAD_FILT;
                end
            endcase
            // Only counter two has a filter bypass
            if (mode == MODE_QUAD_RAW) begin
                sa = i_counter_a_input[ch];
                sb = i_counter_b_input[ch];
            end else begin
                sa = st_r.filt_a[ch];
                sb = st_r.filt_b[ch];
            end
            stp = count_step(mode, sa, sb, st_r.qa_prev[ch], st_r.qb_prev[ch]);
            st_nxt.qa_prev[ch] = sa;
            st_nxt.qb_prev[ch] = sb;
            if (stp[1]) begin
                st_nxt.count[ch] = st_r.count[ch] + 16'h0001;
            end else if (stp[0]) begin
                st_nxt.count[ch] = st_r.count[ch] - 16'h0001;
            end
            if (ch == 2 && stp != 2'b00) begin
                st_nxt.dir3 = stp[1];
            end

            st_nxt.idx_prev[ch] = i_index_pulse_input[ch];
            if (wr_hit && ofs == OFS_INDEX_ONE + 8'(2 * ch)) begin
                st_nxt.idx_flag[ch] = 1'b0;
            end
            if (i_index_pulse_input[ch] & ~st_r.idx_prev[ch]) begin
                // Set wins over a clear in the same cycle
                st_nxt.index_cap[ch] = st_r.count[ch];
                st_nxt.idx_flag[ch]  = 1'b1;
            end

            // PWM compare, centred over two primary periods
            dur = {4'h0, st_r.duty_act[ch]};
            if (st_r.prim_period == 16'h0000) begin
                raw = 1'b0;
            end else if (!st_r.phase) begin
                raw = (st_r.tcount < dur);
            end else begin
                raw = (st_r.tcount >= st_r.prim_period - dur);
            end
            st_nxt.raw_prev[ch] = raw;
            if (raw != st_r.raw_prev[ch]) begin
                st_nxt.dead_cnt[ch] = dead_load;
                st_nxt.pwm_up[ch]   = 1'b0;
                st_nxt.pwm_dn[ch]   = 1'b0;
            end else if (st_r.dead_cnt[ch] != 12'h000) begin
                st_nxt.dead_cnt[ch] = st_r.dead_cnt[ch] - 12'h001;
                st_nxt.pwm_up[ch]   = 1'b0;
                st_nxt.pwm_dn[ch]   = 1'b0;
            end else begin
                st_nxt.pwm_up[ch] = raw & st_r.ctrl[CTL_PWM_EN];
                st_nxt.pwm_dn[ch] = ~raw & st_r.ctrl[CTL_PWM_EN];
            end
            if (!st_r.ctrl[CTL_PWM_EN]) begin
                st_nxt.pwm_up[ch] = 1'b0;
                st_nxt.pwm_dn[ch] = 1'b0;
            end
        end

        // Register writes; unlisted offsets fall through untouched
        if (wr_hit) begin
            case (ofs)
                OFS_DOUT: begin
                    st_nxt.dout = i_io_req.wdata[7:0];
                end
                OFS_CONTROL: begin
                    st_nxt.ctrl = i_io_req.wdata;
                end
                OFS_PRIMARY: begin
                    st_nxt.prim_period = i_io_req.wdata;
                end
                OFS_SECONDARY: begin
                    st_nxt.sec_mult = i_io_req.wdata[7:0];
                    st_nxt.dead_set = i_io_req.wdata[15:8];
                end
                OFS_PWM_U: begin
                    st_nxt.duty_wr[0] = i_io_req.wdata[11:0];
                end
                OFS_PWM_V: begin
                    st_nxt.duty_wr[1] = i_io_req.wdata[11:0];
                end
                OFS_PWM_W: begin
                    st_nxt.duty_wr[2] = i_io_req.wdata[11:0];
                end
                default: begin
                end
            endcase
        end

        // Interrupt flags; a new event beats a clear
        st_nxt.prim_flag = (st_r.prim_flag & ~(wr_hit &&
                           ofs == OFS_CLR_PRIMARY)) | prim_ev;
        st_nxt.sec_flag  = (st_r.sec_flag & ~(wr_hit &&
                           ofs == OFS_CLR_SECONDARY)) | sec_ev;

        // Register reads, captured one cycle after the strobe
        st_nxt.rvalid = rd_hit;
        st_nxt.rdata  = 16'h0000;
        if (rd_hit) begin
            case (ofs)
                OFS_COUNT_ONE:   st_nxt.rdata = st_r.count[0];
                OFS_COUNT_TWO:   st_nxt.rdata = st_r.count[1];
                OFS_COUNT_THREE: st_nxt.rdata = st_r.count[2];
                OFS_INDEX_ONE:   st_nxt.rdata = st_r.index_cap[0];
                OFS_INDEX_TWO:   st_nxt.rdata = st_r.index_cap[1];
                OFS_INDEX_THREE: st_nxt.rdata = st_r.index_cap[2];
                OFS_STATUS:      st_nxt.rdata = status_word;
                OFS_DIN: begin
                    st_nxt.rdata = {8'h00, i_isolated_input_bits};
                end
                default:         st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_r      <= '0;
            st_r.ctrl <= CONTROL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_io_rdata             = st_r.rdata;
    assign o_io_rvalid            = st_r.rvalid;
    assign o_isolated_output_bits = st_r.dout;
    assign o_pwm_upper            = st_r.pwm_up;
    assign o_pwm_lower            = st_r.pwm_dn;
    // Single request line; no register reads back either flag, so software cannot poll for the source
    assign o_irq_request = (st_r.prim_flag & i_primary_irq_enable) |
                           (st_r.sec_flag & i_secondary_irq_enable);

endmodule // encoder_pwm_io

// >>> core/encoder_pwm_io_pkg.sv
// Purpose: Constants and carriers of the encoder counter and PWM I/O card
// Assumes: 20 MHz system clock, 16-bit I/O cycles, 256-byte aligned base
// Notes:   Offsets are byte offsets from the assigned I/O base
//
// Notes on behaviour
// - Decode registers at assigned base, 16-bit accesses
// - Offsets 00h/02h/04h return counter values
// - Index edge copies counter, sets latched flag
// - Writing index register clears its flag
// - Flags at status bits 6,5,4; reset zero
// - Status shows extra inputs; fixed ones, zeros
// - Status bit 8 shows counter three direction
// - Low byte at 10h drives isolated outputs
// - Bit 0: counter one up/down or quadrature
// - Bits 2:1 pick counter two's four modes
// - Bits 4:3 pick filter time; shorter ignored
// - Bit 7 enables PWM outputs; else zero
// - Offset 16h loads primary timer period
// - Byte 18h holds secondary interrupt multiplier
// - Byte 19h holds shared PWM dead time
// - 1Ah/1Ch/1Eh take 12-bit PWM durations
// - Offset 40h reads isolated input levels
// - Writes to 80h/90h clear interrupt flags
// - Primary timer counts 10 MHz time base
// - Secondary fires every n+1 primary periods
// - Dead time is 0.75 us times (m+1)
// - Carrier half primary rate; duration updates per period
package encoder_pwm_io_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_COUNT_ONE     = 8'h00;
    localparam logic [7:0] OFS_COUNT_TWO     = 8'h02;
    localparam logic [7:0] OFS_COUNT_THREE   = 8'h04;
    localparam logic [7:0] OFS_INDEX_ONE     = 8'h06;
    localparam logic [7:0] OFS_INDEX_TWO     = 8'h08;
    localparam logic [7:0] OFS_INDEX_THREE   = 8'h0A;
    localparam logic [7:0] OFS_STATUS        = 8'h0C;
    localparam logic [7:0] OFS_DOUT          = 8'h10;
    localparam logic [7:0] OFS_CONTROL       = 8'h12;
    localparam logic [7:0] OFS_PRIMARY       = 8'h16;
    localparam logic [7:0] OFS_SECONDARY     = 8'h18;
    localparam logic [7:0] OFS_PWM_U         = 8'h1A;
    localparam logic [7:0] OFS_PWM_V         = 8'h1C;
    localparam logic [7:0] OFS_PWM_W         = 8'h1E;
    localparam logic [7:0] OFS_DIN           = 8'h40;
    localparam logic [7:0] OFS_CLR_PRIMARY   = 8'h80;
    localparam logic [7:0] OFS_CLR_SECONDARY = 8'h90;

    // ************************************************************
    // Control word fields and reset values
    // ************************************************************
    localparam int          CTL_C1_MODE    = 0;
    localparam int          CTL_C2_MODE_LO = 1;
    localparam int          CTL_FILT_LO    = 3;
    localparam int          CTL_PWM_EN     = 7;
    localparam logic [15:0] CONTROL_RESET  = 16'h0001;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLOCK_MHZ      = 20;
    localparam int TICK_NS        = 100;
    localparam int TICK_CYCLES    = TICK_NS * CLOCK_MHZ / 1000;
    localparam int FILT0_NS       = 300;
    localparam int FILT1_NS       = 600;
    localparam int FILT2_NS       = 1200;
    localparam int FILT3_NS       = 4800;
    localparam logic [6:0] FILT0_CYCLES = 7'((FILT0_NS*CLOCK_MHZ+999)/1000);
    localparam logic [6:0] FILT1_CYCLES = 7'((FILT1_NS*CLOCK_MHZ+999)/1000);
    localparam logic [6:0] FILT2_CYCLES = 7'((FILT2_NS*CLOCK_MHZ+999)/1000);
    localparam logic [6:0] FILT3_CYCLES = 7'((FILT3_NS*CLOCK_MHZ+999)/1000);
    localparam int          DEAD_UNIT_NS = 750;
    localparam logic [11:0] DEAD_UNIT_CYCLES =
        12'((DEAD_UNIT_NS * CLOCK_MHZ + 999) / 1000);

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_PULSE_DIR,
        MODE_UP_DOWN,
        MODE_QUAD_RAW,
        MODE_QUAD_FILT
    } count_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } io_req_s;

    typedef struct packed {
        logic [2:0][15:0] count;
        logic [2:0][15:0] index_cap;
        logic [2:0]       idx_flag;
        logic [2:0]       idx_prev;
        logic [2:0]       filt_a;
        logic [2:0]       filt_b;
        logic [2:0][6:0]  fcnt_a;
        logic [2:0][6:0]  fcnt_b;
        logic [2:0]       qa_prev;
        logic [2:0]       qb_prev;
        logic             dir3;
        logic [7:0]       dout;
        logic [15:0]      ctrl;
        logic [15:0]      prim_period;
        logic [7:0]       sec_mult;
        logic [7:0]       dead_set;
        logic [2:0][11:0] duty_wr;
        logic [2:0][11:0] duty_act;
        logic [4:0]       prescale;
        logic [15:0]      tcount;
        logic [7:0]       scount;
        logic             phase;
        logic             prim_flag;
        logic             sec_flag;
        logic [2:0]       raw_prev;
        logic [2:0][11:0] dead_cnt;
        logic [2:0]       pwm_up;
        logic [2:0]       pwm_dn;
        logic [15:0]      rdata;
        logic             rvalid;
    } card_state_s;

endpackage

// >>> tb/encoder_pwm_io_asserts.sv
// Purpose: Concurrent checks on the card's register port and outputs
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Sees top-level ports only; bound below
`timescale 1ns/1ps
module encoder_pwm_io_asserts (
    input wire logic                        i_clock,
    input wire logic                        i_sys_rst,
    input wire logic [15:0]                 i_io_base,
    input wire encoder_pwm_io_pkg::io_req_s i_io_req,
    input wire logic [15:0]                 o_io_rdata,
    input wire logic                        o_io_rvalid,
    input wire logic [2:0]                  i_extra_differential_inputs,
    input wire logic [7:0]                  i_isolated_input_bits,
    input wire logic                        i_primary_irq_enable,
    input wire logic                        i_secondary_irq_enable,
    input wire logic [7:0]                  o_isolated_output_bits,
    input wire logic [2:0]                  o_pwm_upper,
    input wire logic [2:0]                  o_pwm_lower,
    input wire logic                        o_irq_request
);
    import encoder_pwm_io_pkg::*;
    // ************************************************************
    // Decode helpers
    // ************************************************************
    logic       rd_hit;
    logic       wr_hit;
    logic [7:0] ofs;
    assign rd_hit = i_io_req.rd && (i_io_req.addr[15:8] == i_io_base[15:8]);
    assign wr_hit = i_io_req.wr && (i_io_req.addr[15:8] == i_io_base[15:8]);
    assign ofs    = {i_io_req.addr[7:1], 1'b0};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_read_answer: assert property (rd_hit |=> o_io_rvalid)
        else $error("read in window not answered");
    a_miss_silent: assert property (!rd_hit |=> !o_io_rvalid)
        else $error("answer without a read in window");
    a_idle_zero: assert property (!o_io_rvalid |->
        o_io_rdata == 16'h0000) else $error("read data not zero while idle");
    a_din_value: assert property (rd_hit && ofs == OFS_DIN |=>
        o_io_rdata == {8'h00, $past(i_isolated_input_bits)})
        else $error("input levels read wrong");
    a_status_fixed: assert property (rd_hit && ofs == OFS_STATUS |=>
        o_io_rdata[15:9] == 7'h00 && o_io_rdata[7] && o_io_rdata[3]
        && o_io_rdata[2:0] == $past(i_extra_differential_inputs))
        else $error("status fixed bits or inputs wrong");
    a_wo_zero: assert property (rd_hit && (ofs == OFS_CONTROL
        || ofs == 8'h14) |=> o_io_rdata == 16'h0000)
        else $error("write-only or reserved read not zero");
    a_dout_load: assert property (wr_hit && ofs == OFS_DOUT |=>
        o_isolated_output_bits == $past(i_io_req.wdata[7:0]))
        else $error("output latch not loaded");
    a_pwm_off: assert property (wr_hit && ofs == OFS_CONTROL
        && !i_io_req.wdata[7] |-> ##2
        (o_pwm_upper == 3'b000 && o_pwm_lower == 3'b000) [*4])
        else $error("pwm outputs active while disabled");
    a_pair_apart: assert property (!(|(o_pwm_upper & o_pwm_lower)))
        else $error("both sides of a pwm pair on");
    a_irq_gated: assert property (o_irq_request |->
        i_primary_irq_enable || i_secondary_irq_enable)
        else $error("interrupt request with no source enabled");

    c_read: cover property (rd_hit ##1 o_io_rvalid);
    c_dout: cover property (wr_hit && ofs == OFS_DOUT);
    c_irq: cover property ($rose(o_irq_request));
endmodule // encoder_pwm_io_asserts

bind encoder_pwm_io encoder_pwm_io_asserts u_chk (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_io_base(i_io_base),
    .i_io_req(i_io_req), .o_io_rdata(o_io_rdata),
    .o_io_rvalid(o_io_rvalid),
    .i_extra_differential_inputs(i_extra_differential_inputs),
    .i_isolated_input_bits(i_isolated_input_bits),
    .i_primary_irq_enable(i_primary_irq_enable),
    .i_secondary_irq_enable(i_secondary_irq_enable),
    .o_isolated_output_bits(o_isolated_output_bits),
    .o_pwm_upper(o_pwm_upper), .o_pwm_lower(o_pwm_lower),
    .o_irq_request(o_irq_request));

// >>> tb/io_host_model.sv
// Purpose: Host processor issuing 16-bit I/O cycles to the card
// Assumes: Read answer is sampled 2 ns after the edge that takes the cycle
// Notes:   Released address and data are inverted, never left stale
`timescale 1ns/1ps
module io_host_model #(
    parameter logic [15:0] BASE = 16'h0300
) (
    input  wire logic                   i_clock,
    output encoder_pwm_io_pkg::io_req_s o_io_req,
    input  wire logic [15:0]            i_io_rdata,
    input  wire logic                   i_io_rvalid
);
    initial o_io_req = '0;
    task automatic io_cycle(input logic [7:0] ofs, input logic rd,
                            input logic [15:0] wdata,
                            output logic [15:0] rdata);
        @(posedge i_clock);
        #2;
        o_io_req = '{addr: BASE | {8'h00, ofs}, rd: rd, wr: !rd,
                     wdata: wdata};
        @(posedge i_clock);
        #2;
        rdata = (i_io_rvalid === 1'b1) ? i_io_rdata : 16'hXXXX;
        o_io_req = '{addr: ~o_io_req.addr, rd: 1'b0, wr: 1'b0,
                     wdata: ~wdata};
    endtask
    task automatic io_write(input logic [7:0] ofs, input logic [15:0] d);
        logic [15:0] unused;
        io_cycle(ofs, 1'b0, d, unused);
    endtask
    task automatic io_read(input logic [7:0] ofs, output logic [15:0] d);
        io_cycle(ofs, 1'b1, 16'h0000, d);
    endtask
    task automatic io_ack(input logic [7:0] ofs);
        io_write(ofs, 16'h0000);
    endtask
endmodule // io_host_model

// >>> tb/encoder_pwm_io_tb_top.sv
// Purpose: Register-level tests of the encoder counter and PWM card
// Assumes: 20 MHz clock, inputs driven 2 ns after the rising edge
// Notes:   Timer gaps measured between interrupt request rises
`timescale 1ns/1ps
module encoder_pwm_io_tb_top;
    import encoder_pwm_io_pkg::*;
    localparam logic [7:0] WO_LIST [7] = '{OFS_DOUT, OFS_CONTROL, 8'h14,
        OFS_PRIMARY, OFS_SECONDARY, OFS_PWM_U, OFS_CLR_PRIMARY};
    logic i_clock, i_sys_rst, rvalid, en0, en1, irq, seen;
    logic [15:0] rdata, rd_val;
    logic [2:0]  a_in, b_in, idx_in, extra_in, pwm_up, pwm_dn;
    logic [7:0]  din, dout;
    io_req_s     io_req;
    int          err_count, cmp_count, gap;

    encoder_pwm_io u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_io_base(16'h0300), .i_io_req(io_req), .o_io_rdata(rdata),
        .o_io_rvalid(rvalid), .i_counter_a_input(a_in),
        .i_counter_b_input(b_in), .i_index_pulse_input(idx_in),
        .i_extra_differential_inputs(extra_in),
        .i_isolated_input_bits(din), .i_primary_irq_enable(en0),
        .i_secondary_irq_enable(en1), .o_isolated_output_bits(dout),
        .o_pwm_upper(pwm_up), .o_pwm_lower(pwm_dn), .o_irq_request(irq));
    io_host_model #(.BASE(16'h0300)) u_host (.i_clock(i_clock),
        .o_io_req(io_req), .i_io_rdata(rdata), .i_io_rvalid(rvalid));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] ofs,
                          input logic [15:0] exp);
        u_host.io_read(ofs, rd_val);
        chk(what, exp, rd_val);
    endtask
    task automatic drive(input logic [2:0] am, input logic [2:0] bm,
                         input int len);
        @(posedge i_clock);
        #2;
        a_in = am;
        b_in = bm;
        repeat (len) @(posedge i_clock);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge i_clock);
            #2;
            n++;
        end
    endtask
    // Clear first so a flag left pending never fakes the first rise
    task automatic irq_gap(input logic [7:0] ack, output int g);
        time t0;
        u_host.io_ack(ack);
        wait_irq();
        t0 = $time;
        u_host.io_ack(ack);
        wait_irq();
        g = int'(($time - t0) / 50);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        err_count++;
        end_sim();
    end
    initial begin
        {i_sys_rst, en0, en1, a_in, b_in, idx_in} = {3'b100, 9'h000};
        extra_in = 3'b101;
        din = 8'hC3;
        repeat (2) @(posedge i_clock);
        #2;
        i_sys_rst = 1'b0;
        rd_chk("status", OFS_STATUS, 16'h008D);
        rd_chk("count1", OFS_COUNT_ONE, 16'h0000);
        drive(3'b111, 3'b000, 12);
        drive(3'b111, 3'b111, 12);
        drive(3'b000, 3'b111, 12);
        drive(3'b000, 3'b000, 12);
        u_host.io_write(OFS_CONTROL, 16'h0002);
        repeat (3) begin
            drive(3'b011, 3'b000, 12);
            drive(3'b000, 3'b000, 12);
        end
        drive(3'b011, 3'b000, 2);
        drive(3'b000, 3'b011, 12);
        drive(3'b000, 3'b000, 12);
        u_host.io_write(OFS_COUNT_ONE, 16'hFFFF);
        rd_chk("count1", OFS_COUNT_ONE, 16'h0006);
        rd_chk("count2", OFS_COUNT_TWO, 16'h0001);
        rd_chk("count3", OFS_COUNT_THREE, 16'h0004);
        idx_in = 3'b001;
        repeat (4) @(posedge i_clock);
        #2;
        idx_in = 3'b000;
        rd_chk("index1", OFS_INDEX_ONE, 16'h0006);
        rd_chk("status", OFS_STATUS, 16'h01CD);
        u_host.io_write(OFS_INDEX_ONE, 16'hFFFF);
        rd_chk("status", OFS_STATUS, 16'h018D);
        u_host.io_write(OFS_DOUT, 16'hA55A);
        chk("dout", 16'h005A, {8'h00, dout});
        rd_chk("din", OFS_DIN, 16'h00C3);
        foreach (WO_LIST[i]) rd_chk("wo", WO_LIST[i], 16'h0000);
        u_host.io_write(OFS_PRIMARY, 16'd50);
        u_host.io_write(OFS_SECONDARY, 16'h0002);
        u_host.io_write(OFS_PWM_U, 16'hF014);
        en0 = 1'b1;
        irq_gap(OFS_CLR_PRIMARY, gap);
        chk("primary gap", 16'd100, 16'(gap));
        en0 = 1'b0;
        en1 = 1'b1;
        irq_gap(OFS_CLR_SECONDARY, gap);
        chk("secondary gap", 16'd300, 16'(gap));
        u_host.io_write(OFS_CONTROL, 16'h0082);
        seen = 1'b0;
        repeat (400) begin
            @(posedge i_clock);
            #2;
            if (pwm_up[0] === 1'b1) seen = 1'b1;
        end
        chk("pwm u on", 16'h0001, {15'h0000, seen});
        u_host.io_write(OFS_CONTROL, 16'h0002);
        repeat (2) @(posedge i_clock);
        #2;
        chk("pwm off", 16'h0000, {10'h000, pwm_up, pwm_dn});
        end_sim();
    end
endmodule // encoder_pwm_io_tb_top
